//--- core/dih_top.sv
// Dual-image hsync override: AXI4-Lite registers, line measurement and
// per-port sync regeneration. Assumes video inputs on the aclk domain.
`timescale 1ns/1ps
// Summary of operation
// - Override timing acts only in dual-image (3D or splitter) operation.
// - Measure incoming back porch and regenerate outgoing porch from it.
// - Back-porch enable bit 7 selects the programmed porch value.
// - Measure incoming sync width and regenerate outgoing pulse from it.
// - Sync-width enable bit 3 selects the programmed width value.
// - Back-porch value bits 9:8 live in control bits 5-4.
// - Back-porch value bits 7:0 live in the third register.
// - Sync-width value bits 9:8 live in control bits 1-0.
// - Sync-width value bits 7:0 live in the second register.
// - In independent mode registers act on the selected port; otherwise writes reach both ports.
// - All three override registers reset to zero, overrides off.
module dih_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [dih_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [dih_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [dih_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [dih_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic vid_hsync,
   input wire logic vid_de,
   output logic [dih_pkg::NPORT-1:0] out_hsync,
   output logic [dih_pkg::NPORT-1:0] out_porch
);
   localparam int unsigned NP = dih_pkg::NPORT;
   localparam int unsigned RW = dih_pkg::REG_W;
   localparam int unsigned VW = dih_pkg::VAL_W;

   // Word index of a byte address; low two bits are ignored
   function automatic logic [dih_pkg::IDX_W-1:0] reg_idx(input logic [dih_pkg::ADDR_W-1:0] a);
      reg_idx = a[dih_pkg::ADDR_W-1:2];
   endfunction

   // Unmapped indices answer DECERR
   function automatic logic idx_mapped(input logic [dih_pkg::IDX_W-1:0] i);
      if (i == dih_pkg::IDX_CTL0) begin
         idx_mapped = 1'b1;
      end else if (i == dih_pkg::IDX_SW_LO) begin
         idx_mapped = 1'b1;
      end else if (i == dih_pkg::IDX_BP_LO) begin
         idx_mapped = 1'b1;
      end else if (i == dih_pkg::IDX_MODE) begin
         idx_mapped = 1'b1;
      end else if (i == dih_pkg::IDX_MEAS_SW) begin
         idx_mapped = 1'b1;
      end else begin
         idx_mapped = (i == dih_pkg::IDX_MEAS_BP);
      end
   endfunction

   // Write channel holding state
   logic awready_q, wready_q, bvalid_q;
   logic [1:0] bresp_q;
   logic aw_got_q, w_got_q;
   logic [dih_pkg::ADDR_W-1:0] waddr_q;
   logic [RW-1:0] wbyte_q;
   logic wlane_q;
   logic aw_take, w_take, b_done, wr_fire;
   logic [dih_pkg::IDX_W-1:0] widx;

   // Read channel state
   logic arready_q, rvalid_q;
   logic [1:0] rresp_q;
   logic [dih_pkg::DATA_W-1:0] rdata_q;
   logic ar_take, r_done;
   logic [dih_pkg::IDX_W-1:0] ridx;

   // Register storage, one override set per serial output port, one shared mode
   logic [RW-1:0] ctl0_q [NP];
   logic [RW-1:0] sw_lo_q [NP];
   logic [RW-1:0] bp_lo_q [NP];
   logic [dih_pkg::MODE_W-1:0] mode_q;

   logic dual_en, indep_mode, port_sel;
   logic [NP-1:0] wr_port;
   logic wr_ctl0, wr_sw_lo, wr_bp_lo, wr_mode;
   logic [VW-1:0] meas_sw, meas_bp;
   logic [NP-1:0] hs_out, bp_out;
   logic [RW-1:0] rd_ctl0, rd_sw_lo, rd_bp_lo;
   logic [dih_pkg::DATA_W-1:0] rd_word;

   assign aw_take = s_axi_awvalid & awready_q;
   assign w_take = s_axi_wvalid & wready_q;
   assign b_done = bvalid_q & s_axi_bready;
   // A pending answer blocks a second fire
   assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
   assign widx = reg_idx(waddr_q);

   // Mode bits: dual, independent, port select
   assign dual_en = mode_q[dih_pkg::MODE_DUAL_BIT];
   assign indep_mode = mode_q[dih_pkg::MODE_INDEP_BIT];
   assign port_sel = mode_q[dih_pkg::MODE_PSEL_BIT];

   assign wr_port = indep_mode ? (NP'(1) << port_sel) : {NP{1'b1}};

   // Only byte lane 0 carries register data; other lanes are ignored
   assign wr_ctl0 = wr_fire & wlane_q & (widx == dih_pkg::IDX_CTL0);
   assign wr_sw_lo = wr_fire & wlane_q & (widx == dih_pkg::IDX_SW_LO);
   assign wr_bp_lo = wr_fire & wlane_q & (widx == dih_pkg::IDX_BP_LO);
   assign wr_mode = wr_fire & wlane_q & (widx == dih_pkg::IDX_MODE);

   // Write address and data are taken in either order, then answered together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= '0;
         wbyte_q <= dih_pkg::REG_RESET;
         wlane_q <= 1'b0;
      end else if (ce) begin
         if (aw_take) begin
            awready_q <= 1'b0;
            aw_got_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
         end else if (b_done) begin
            awready_q <= 1'b1;
            aw_got_q <= 1'b0;
         end
         // Upper data lanes are dropped
         if (w_take) begin
            wready_q <= 1'b0;
            w_got_q <= 1'b1;
            wbyte_q <= s_axi_wdata[RW-1:0];
            wlane_q <= s_axi_wstrb[0];
         end else if (b_done) begin
            wready_q <= 1'b1;
            w_got_q <= 1'b0;
         end
      end
   end

   // Answer two cycles after the later half is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= dih_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= idx_mapped(widx) ? dih_pkg::RESP_OKAY : dih_pkg::RESP_DECERR;
         end else if (b_done) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // One mode for both ports
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= dih_pkg::MODE_RESET;
      end else if (ce && wr_mode) begin
         mode_q <= wbyte_q[dih_pkg::MODE_W-1:0];
      end
   end

   // Per-port override registers
   genvar p;
   generate
      for (p = 0; p < NP; p++) begin : g_port
         logic [VW-1:0] sw_ovr, bp_ovr, sw_eff, bp_eff;

         // Shared mode writes both sets alike
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ctl0_q[p] <= dih_pkg::REG_RESET;
               sw_lo_q[p] <= dih_pkg::REG_RESET;
               bp_lo_q[p] <= dih_pkg::REG_RESET;
            end else if (ce && wr_port[p]) begin
               if (wr_ctl0) begin
                  ctl0_q[p] <= wbyte_q & dih_pkg::CTL0_WMASK;
               end
               if (wr_sw_lo) begin
                  sw_lo_q[p] <= wbyte_q;
               end
               if (wr_bp_lo) begin
                  bp_lo_q[p] <= wbyte_q;
               end
            end
         end

         assign sw_ovr = {ctl0_q[p][dih_pkg::SW_HI_LSB +: dih_pkg::HI_W], sw_lo_q[p]};
         assign bp_ovr = {ctl0_q[p][dih_pkg::BP_HI_LSB +: dih_pkg::HI_W], bp_lo_q[p]};

         assign sw_eff = ctl0_q[p][dih_pkg::SW_EN_BIT] ? sw_ovr : meas_sw;
         assign bp_eff = ctl0_q[p][dih_pkg::BP_EN_BIT] ? bp_ovr : meas_bp;

         dih_hregen u_regen (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .dual_en(dual_en),
            .hsync_in(vid_hsync),
            .sync_w(sw_eff),
            .porch_w(bp_eff),
            .hsync_out_q(hs_out[p]),
            .porch_out_q(bp_out[p])
         );
      end
   endgenerate

   // Each regenerator registers its own outputs
   assign out_hsync = hs_out;
   assign out_porch = bp_out;

   dih_hmeasure u_meas (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .hsync(vid_hsync),
      .de(vid_de),
      .sync_w_q(meas_sw),
      .porch_w_q(meas_bp)
   );

   // Reads show the selected port in independent mode, else port 0
   assign rd_ctl0 = ctl0_q[indep_mode & port_sel];
   assign rd_sw_lo = sw_lo_q[indep_mode & port_sel];
   assign rd_bp_lo = bp_lo_q[indep_mode & port_sel];

   // Data is captured at the address handshake
   assign ar_take = s_axi_arvalid & arready_q;
   assign r_done = rvalid_q & s_axi_rready;
   assign ridx = reg_idx(s_axi_araddr);

   // Unmapped reads return zero
   always_comb begin
      rd_word = '0;
      if (ridx == dih_pkg::IDX_CTL0) begin
         rd_word[RW-1:0] = rd_ctl0;
      end else if (ridx == dih_pkg::IDX_SW_LO) begin
         rd_word[RW-1:0] = rd_sw_lo;
      end else if (ridx == dih_pkg::IDX_BP_LO) begin
         rd_word[RW-1:0] = rd_bp_lo;
      end else if (ridx == dih_pkg::IDX_MODE) begin
         rd_word[dih_pkg::MODE_W-1:0] = mode_q;
      end else if (ridx == dih_pkg::IDX_MEAS_SW) begin
         rd_word[VW-1:0] = meas_sw;
      end else if (ridx == dih_pkg::IDX_MEAS_BP) begin
         rd_word[VW-1:0] = meas_bp;
      end
   end

   // One read in flight until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= dih_pkg::RESP_OKAY;
         rdata_q <= '0;
      end else if (ce) begin
         if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= idx_mapped(ridx) ? dih_pkg::RESP_OKAY : dih_pkg::RESP_DECERR;
         end else if (r_done) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
         end
      end
   end

   // Bus outputs straight from flip-flops
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
endmodule

//--- core/dih_pkg.sv
// Constants for the dual-image horizontal sync override block.
// Assumes a 32-bit AXI4-Lite register bus and one pixel clock domain.
package dih_pkg;
   // Bus and value widths
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;
   localparam int unsigned IDX_W = 8;
   localparam int unsigned VAL_W = 10;
   localparam int unsigned NPORT = 2;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CTL0 = 8'h6a;
   localparam logic [IDX_W-1:0] IDX_SW_LO = 8'h6b;
   localparam logic [IDX_W-1:0] IDX_BP_LO = 8'h6c;
   localparam logic [IDX_W-1:0] IDX_MODE = 8'h70;
   localparam logic [IDX_W-1:0] IDX_MEAS_SW = 8'h71;
   localparam logic [IDX_W-1:0] IDX_MEAS_BP = 8'h72;

   // Fields of hsync_override_control
   localparam int unsigned BP_EN_BIT = 7;
   localparam int unsigned BP_HI_LSB = 4;
   localparam int unsigned SW_EN_BIT = 3;
   localparam int unsigned SW_HI_LSB = 0;
   localparam int unsigned HI_W = 2;
   localparam logic [REG_W-1:0] CTL0_WMASK = 8'hbb;
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;

   // Fields of the mode register
   localparam int unsigned MODE_DUAL_BIT = 0;
   localparam int unsigned MODE_INDEP_BIT = 1;
   localparam int unsigned MODE_PSEL_BIT = 2;
   localparam int unsigned MODE_W = 3;
   localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   localparam logic [VAL_W-1:0] VAL_ZERO = 10'h000;
   localparam logic [VAL_W-1:0] VAL_ONE = 10'h001;
   localparam logic [VAL_W-1:0] VAL_MAX = 10'h3ff;

   typedef enum logic [1:0] {
      MS_IDLE = 2'b00,
      MS_SYNC = 2'b01,
      MS_PORCH = 2'b10
   } dih_meas_t;

   typedef enum logic [1:0] {
      RG_IDLE = 2'b00,
      RG_SYNC = 2'b01,
      RG_PORCH = 2'b10
   } dih_regen_t;
endpackage

//--- core/dih_hmeasure.sv
// Measures sync pulse width and back porch of the incoming video line.
// Assumes hsync and de come from logic on the same pixel clock.
`timescale 1ns/1ps
module dih_hmeasure (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic hsync,
   input wire logic de,
   output logic [dih_pkg::VAL_W-1:0] sync_w_q,
   output logic [dih_pkg::VAL_W-1:0] porch_w_q
);
   dih_pkg::dih_meas_t st_q, st_d;
   logic [dih_pkg::VAL_W-1:0] cnt_q, cnt_d;
   logic [dih_pkg::VAL_W-1:0] sync_w_d, porch_w_d;
   logic [dih_pkg::VAL_W-1:0] cnt_inc;

   // Saturate so a broken line never wraps to a short value
   assign cnt_inc = (cnt_q == dih_pkg::VAL_MAX) ? cnt_q : cnt_q + dih_pkg::VAL_ONE;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sync_w_d = sync_w_q;
      porch_w_d = porch_w_q;
      case (st_q)
         dih_pkg::MS_IDLE: begin
            if (hsync) begin
               st_d = dih_pkg::MS_SYNC;
               cnt_d = dih_pkg::VAL_ONE;
            end
         end
         dih_pkg::MS_SYNC: begin
            if (hsync) begin
               cnt_d = cnt_inc;
            end else begin
               sync_w_d = cnt_q;
               cnt_d = dih_pkg::VAL_ONE;
               if (de) begin
                  porch_w_d = dih_pkg::VAL_ZERO;
                  st_d = dih_pkg::MS_IDLE;
               end else begin
                  st_d = dih_pkg::MS_PORCH;
               end
            end
         end
         dih_pkg::MS_PORCH: begin
            if (de) begin
               porch_w_d = cnt_q;
               st_d = dih_pkg::MS_IDLE;
            end else if (hsync) begin
               st_d = dih_pkg::MS_IDLE;
            end else begin
               cnt_d = cnt_inc;
            end
         end
         default: st_d = dih_pkg::MS_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= dih_pkg::MS_IDLE;
         cnt_q <= dih_pkg::VAL_ZERO;
         sync_w_q <= dih_pkg::VAL_ZERO;
         porch_w_q <= dih_pkg::VAL_ZERO;
      end else if (ce) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sync_w_q <= sync_w_d;
         porch_w_q <= porch_w_d;
      end
   end
endmodule

//--- core/dih_hregen.sv
// Regenerates one output port's hsync pulse and back porch window.
// Assumes hsync_in is on the same clock; widths are sampled at line start.
`timescale 1ns/1ps
module dih_hregen (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic dual_en,
   input wire logic hsync_in,
   input wire logic [dih_pkg::VAL_W-1:0] sync_w,
   input wire logic [dih_pkg::VAL_W-1:0] porch_w,
   output logic hsync_out_q,
   output logic porch_out_q
);
   dih_pkg::dih_regen_t st_q, st_d;
   logic [dih_pkg::VAL_W-1:0] cnt_q, cnt_d;
   logic [dih_pkg::VAL_W-1:0] porch_l_q, porch_l_d;
   logic hs_prev_q;
   logic rise;

   assign rise = hsync_in & ~hs_prev_q;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      porch_l_d = porch_l_q;
      if (!dual_en) begin
         st_d = dih_pkg::RG_IDLE;
      end else begin
         case (st_q)
            dih_pkg::RG_IDLE: begin
               if (rise) begin
                  // Latch both lengths so a mid-line write cannot tear a line
                  porch_l_d = porch_w;
                  if (sync_w != dih_pkg::VAL_ZERO) begin
                     st_d = dih_pkg::RG_SYNC;
                     cnt_d = sync_w - dih_pkg::VAL_ONE;
                  end else if (porch_w != dih_pkg::VAL_ZERO) begin
                     st_d = dih_pkg::RG_PORCH;
                     cnt_d = porch_w - dih_pkg::VAL_ONE;
                  end
               end
            end
            dih_pkg::RG_SYNC: begin
               if (cnt_q != dih_pkg::VAL_ZERO) begin
                  cnt_d = cnt_q - dih_pkg::VAL_ONE;
               end else if (porch_l_q != dih_pkg::VAL_ZERO) begin
                  st_d = dih_pkg::RG_PORCH;
                  cnt_d = porch_l_q - dih_pkg::VAL_ONE;
               end else begin
                  st_d = dih_pkg::RG_IDLE;
               end
            end
            dih_pkg::RG_PORCH: begin
               if (cnt_q != dih_pkg::VAL_ZERO) begin
                  cnt_d = cnt_q - dih_pkg::VAL_ONE;
               end else begin
                  st_d = dih_pkg::RG_IDLE;
               end
            end
            default: st_d = dih_pkg::RG_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= dih_pkg::RG_IDLE;
         cnt_q <= dih_pkg::VAL_ZERO;
         porch_l_q <= dih_pkg::VAL_ZERO;
         hs_prev_q <= 1'b0;
         hsync_out_q <= 1'b0;
         porch_out_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         porch_l_q <= porch_l_d;
         hs_prev_q <= hsync_in;
         // Outside dual-image operation the input sync passes through
         hsync_out_q <= dual_en ? (st_d == dih_pkg::RG_SYNC) : hsync_in;
         porch_out_q <= dual_en & (st_d == dih_pkg::RG_PORCH);
      end
   end
endmodule

//--- bench/dih_top_sva.sv
// Concurrent checks on the register bus and the regenerated sync outputs.
// Assumes one aclk domain, synchronous active-low aresetn, ports of dih_top.
`timescale 1ns/1ps
module dih_top_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [dih_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic vid_hsync,
   input wire logic [dih_pkg::NPORT-1:0] out_hsync,
   input wire logic [dih_pkg::NPORT-1:0] out_porch
);
   // Frozen cycles under ce low are not judged
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("read data dropped");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
      && s_axi_wready) else $error("write channel not freed");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not freed");
   a_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp == dih_pkg::RESP_DECERR |-> s_axi_rdata == 32'h0)
      else $error("error read returns data");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0)
      else $error("unused read bits set");
   a_sync_cause: assert property (|(out_hsync & ~$past(out_hsync)) |-> $past(vid_hsync)
      && !$past(vid_hsync, 2)) else $error("output sync without input edge");
   a_phase_apart: assert property ((out_hsync & out_porch) == 2'h0)
      else $error("sync and porch overlap");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_decerr: cover property (s_axi_rvalid && s_axi_rresp == dih_pkg::RESP_DECERR);
   c_porch1: cover property ($fell(out_porch[1]));
endmodule

bind dih_top dih_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .vid_hsync(vid_hsync), .out_hsync(out_hsync), .out_porch(out_porch));

//--- bench/dih_vid_src.sv
// Video source model: one line per go pulse, sync then porch then active.
// Assumes go is raised only while busy is low.
`timescale 1ns/1ps
module dih_vid_src (
   input wire logic aclk,
   input wire logic go,
   input wire logic [9:0] sw,
   input wire logic [9:0] bp,
   output logic hsync,
   output logic de,
   output logic busy
);
   logic [11:0] cnt_q;
   initial busy = 1'b0;
   initial cnt_q = 12'h0;
   always @(posedge aclk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         cnt_q <= 12'h0;
      end else if (busy) begin
         cnt_q <= cnt_q + 12'h1;
         if (cnt_q == sw + bp + 12'h14) busy <= 1'b0;
      end
   end
   // Porch is the gap between sync fall and active data
   assign hsync = busy && cnt_q < sw;
   assign de = busy && cnt_q >= sw + bp && cnt_q < sw + bp + 12'h14;
endmodule

//--- bench/dual_image_hsync_override_tb.sv
// Self-checking bench: AXI4-Lite register traffic and regenerated line timing.
// Assumes dih_top and a video source model on aclk.
`timescale 1ns/1ps
module dual_image_hsync_override_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [9:0] awaddr = 10'h0, araddr = 10'h0, sw = 10'h0, bp = 10'h0, msw = 10'h0, mbp = 10'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, go = 1'b0, ce = 1'b1;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, vh, vd, busy;
   logic [1:0] bresp, rresp, oh, op, ph = 2'h0, pp = 2'h0;
   logic [7:0] c0[2] = '{8'h0, 8'h0}, swl[2] = '{8'h0, 8'h0}, bpl[2] = '{8'h0, 8'h0};
   logic [9:0] wc[2] = '{10'h0, 10'h0}, bc[2] = '{10'h0, 10'h0};
   logic [2:0] mode = 3'h0;
   // Seed 79562
   logic [19:0] lf = 20'h136ca;
   logic [33:0] bus_q[$];
   logic [19:0] ln_q[2][$];
   int err_count = 0, samples_checked = 0;

   always #20 aclk = ~aclk;

   dih_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .vid_hsync(vh), .vid_de(vd),
      .out_hsync(oh), .out_porch(op));
   dih_vid_src u_src (.aclk(aclk), .go(go), .sw(sw), .bp(bp), .hsync(vh), .de(vd), .busy(busy));

   function automatic logic [19:0] rnd();
      lf = {lf[18:0], lf[19] ^ lf[16]};
      return lf;
   endfunction
   function automatic logic [9:0] rv();
      logic [19:0] t;
      t = rnd();
      return {3'h0, t[6:0]} + 10'h1;
   endfunction

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic fail(input logic [33:0] e, input logic [33:0] g);
      err_count++;
      $display("CHECK FAILED at %0t expected %h got %h", $time, e, g);
   endtask
   task automatic cmp_bus(input logic [33:0] g);
      logic [33:0] e;
      samples_checked++;
      e = (bus_q.size() > 0) ? bus_q.pop_front() : {34{1'bx}};
      if (g !== e) fail(e, g);
   endtask
   task automatic cmp_line(input int p, input logic [19:0] g);
      logic [19:0] e;
      samples_checked++;
      e = (ln_q[p].size() > 0) ? ln_q[p].pop_front() : {20{1'bx}};
      if (g !== e) fail({14'h0, e}, {14'h0, g});
   endtask

   // Result watcher: bus answers and one record per regenerated line
   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready) cmp_bus({bresp, 32'h0});
      if (rvalid === 1'b1 && rready) cmp_bus({rresp, rdata});
      for (int p = 0; p < 2; p++) begin
         if (oh[p] === 1'b1) wc[p]++;
         if (op[p] === 1'b1) bc[p]++;
         if ((ph[p] && oh[p] === 1'b0 && op[p] === 1'b0) || (pp[p] && op[p] === 1'b0)) begin
            cmp_line(p, {wc[p], bc[p]});
            wc[p] = 10'h0;
            bc[p] = 10'h0;
         end
         ph[p] = (oh[p] === 1'b1);
         pp[p] = (op[p] === 1'b1);
      end
   end

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st);
      logic [31:0] e;
      logic [1:0] r;
      int n;
      int ps;
      ps = mode[1] ? int'(mode[2]) : 0;
      r = dih_pkg::RESP_OKAY;
      case (idx)
         8'h6a: e = {24'h0, c0[ps]};
         8'h6b: e = {24'h0, swl[ps]};
         8'h6c: e = {24'h0, bpl[ps]};
         8'h70: e = {29'h0, mode};
         8'h71: e = {22'h0, msw};
         8'h72: e = {22'h0, mbp};
         default: begin
            e = 32'h0;
            r = dih_pkg::RESP_DECERR;
         end
      endcase
      bus_q.push_back({r, wr ? 32'h0 : e});
      @(posedge aclk);
      if (wr) begin
         awaddr <= {idx, 2'h0};
         wdata <= {rnd(), 4'h0, d};
         wstrb <= st;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
      end else begin
         araddr <= {idx, 2'h0};
         arvalid <= 1'b1;
      end
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (n == 3) begin
            bready <= wr;
            rready <= !wr;
         end
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (!(wr ? bvalid === 1'b1 && bready : rvalid === 1'b1 && rready) && n < 60);
      bready <= 1'b0;
      rready <= 1'b0;
      if (n >= 60) begin
         err_count++;
         complete_run();
      end
      if (wr && st[0] && idx == 8'h70) mode = d[2:0];
      for (int p = 0; p < 2; p++) begin
         if (wr && st[0] && (!mode[1] || int'(mode[2]) == p)) begin
            if (idx == 8'h6a) c0[p] = d & dih_pkg::CTL0_WMASK;
            if (idx == 8'h6b) swl[p] = d;
            if (idx == 8'h6c) bpl[p] = d;
         end
      end
   endtask

   task automatic line(input logic [9:0] s, input logic [9:0] b);
      logic [9:0] w, k;
      for (int p = 0; p < 2; p++) begin
         w = c0[p][3] ? {c0[p][1:0], swl[p]} : msw;
         k = c0[p][7] ? {c0[p][5:4], bpl[p]} : mbp;
         if (!mode[0]) ln_q[p].push_back({s, 10'h0});
         else if (w != 10'h0 || k != 10'h0) ln_q[p].push_back({w, k});
      end
      @(posedge aclk);
      sw <= s;
      bp <= b;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      // Gap covers the longest regenerated line this bench programs
      repeat (1100) @(posedge aclk);
      msw = s;
      mbp = b;
   endtask

   initial begin
      logic [9:0] t;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (c0[i]) bus(1'b0, 8'h6a + 8'(i), 8'h0, 4'h0);
      bus(1'b0, 8'h6c, 8'h0, 4'h0);
      bus(1'b0, 8'h71, 8'h0, 4'h0);
      bus(1'b0, 8'h40, 8'h0, 4'h0);
      bus(1'b1, 8'h7f, 8'h55, 4'h1);
      bus(1'b1, 8'h6a, 8'hff, 4'h1);
      bus(1'b0, 8'h6a, 8'h0, 4'h0);
      bus(1'b1, 8'h6a, 8'h00, 4'h0);
      bus(1'b1, 8'h71, 8'h3c, 4'h1);
      bus(1'b0, 8'h6a, 8'h0, 4'h0);
      bus(1'b1, 8'h6a, 8'h00, 4'h1);
      repeat (2) line(rv(), rv());
      bus(1'b1, 8'h70, 8'h01, 4'h1);
      repeat (2) line(rv(), rv());
      bus(1'b0, 8'h72, 8'h0, 4'h0);
      for (int i = 0; i < 4; i++) begin
         t = mbp << 1;
         bus(1'b1, 8'h6b, rnd() >> 12, 4'h1);
         bus(1'b1, 8'h6c, t[7:0], 4'h1);
         bus(1'b1, 8'h6a, {i[1], 3'h5, i[0], 3'h5}, 4'h1);
         bus(1'b0, 8'h6b, 8'h0, 4'h0);
         line(rv(), rv());
      end
      bus(1'b1, 8'h70, 8'h03, 4'h1);
      bus(1'b1, 8'h6a, 8'h88, 4'h1);
      bus(1'b1, 8'h70, 8'h07, 4'h1);
      bus(1'b1, 8'h6a, 8'h19, 4'h1);
      bus(1'b1, 8'h6b, 8'h21, 4'h1);
      bus(1'b0, 8'h6a, 8'h0, 4'h0);
      line(rv(), rv());
      // Frozen line leaves no trace
      ce <= 1'b0;
      sw <= 10'h9;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (200) @(posedge aclk);
      ce <= 1'b1;
      bus(1'b0, 8'h71, 8'h0, 4'h0);
      bus(1'b1, 8'h70, 8'h01, 4'h1);
      bus(1'b0, 8'h6a, 8'h0, 4'h0);
      complete_run();
   end

   initial begin
      repeat (60000) @(posedge aclk);
      err_count++;
      complete_run();
   end
endmodule
